// *** common/fpc_pkg.sv ***
// Purpose: Shared constants and types for the flyback protection control
// Assumes: 100 MHz system clock, analog comparators supply level inputs
// Notes:   Cycle counts are derived from times and the clock rate
package fpc_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 100_000_000;
    localparam int CLK_MHZ = CLK_HZ / 1_000_000;
    localparam int OVL_TIME_MS = 60;
    localparam int OVL_CYCLES = (CLK_HZ / 1000) * OVL_TIME_MS;
    localparam int HP_FREQ_HZ = 65_000;
    localparam int PP_FREQ_HZ = 80_000;
    localparam int LP_FREQ_HZ = 25_000;
    localparam int MAX_DUTY_PCT = 80;
    localparam int BLANK_NS = 300;
    localparam int SAMPLE_US = 2;
    localparam int OVP_COUNT = 4;
    localparam int DUTY_COUNT = 8;
    localparam int OPP_RESTARTS = 3;
    localparam int ONE_RESTART = 1;

    localparam logic [12:0] HP_PERIOD = 13'(CLK_HZ / HP_FREQ_HZ);
    localparam logic [12:0] PP_PERIOD = 13'(CLK_HZ / PP_FREQ_HZ);
    localparam logic [12:0] LP_PERIOD = 13'(CLK_HZ / LP_FREQ_HZ);
    localparam logic [12:0] HP_MAXON =
        13'((CLK_HZ / HP_FREQ_HZ) * MAX_DUTY_PCT / 100);
    localparam logic [12:0] PP_MAXON =
        13'((CLK_HZ / PP_FREQ_HZ) * MAX_DUTY_PCT / 100);
    localparam logic [12:0] LP_MAXON =
        13'((CLK_HZ / LP_FREQ_HZ) * MAX_DUTY_PCT / 100);
    localparam logic [12:0] BLANK_CYCLES =
        13'((BLANK_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] SAMPLE_CYCLES = 8'(SAMPLE_US * CLK_MHZ);

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_CONFIG = 4'h4;
    localparam int CFG_EN_BIT = 0;
    localparam logic CFG_EN_RESET = 1'b1;
    localparam int ST_STATE_LSB = 0;
    localparam int ST_MODE_LSB = 3;
    localparam int ST_EN_BIT = 5;
    localparam int ST_CAUSE_LSB = 6;
    localparam int CAUSE_OTP = 0;
    localparam int CAUSE_SENSE = 1;
    localparam int CAUSE_VCC = 2;

    // ------------------------------------------------------------
    // Synchronised input bit positions
    // ------------------------------------------------------------
    localparam int IN_W = 9;
    localparam int IN_OVL = 0;
    localparam int IN_TRIP = 1;
    localparam int IN_SOVP = 2;
    localparam int IN_VOVP = 3;
    localparam int IN_UNDERVOLTAGE_LOCKOUT = 4;
    localparam int IN_START = 5;
    localparam int IN_OTP = 6;
    localparam int IN_LOW = 7;
    localparam int IN_PEAK = 8;

    typedef enum logic [2:0] {
        ST_WAIT = 3'b000,
        ST_RUN = 3'b001,
        ST_DISCH = 3'b010,
        ST_CHARGE = 3'b011,
        ST_LATCH = 3'b100
    } fpc_state_t;

    typedef enum logic [1:0] {
        MD_HIGH = 2'b00,
        MD_LOW = 2'b01,
        MD_PEAK = 2'b10
    } fpc_mode_t;

endpackage : fpc_pkg

// *** logic/fpc_sync.sv ***
// Purpose: Two-stage synchroniser for a group of level inputs
// Assumes: Inputs are static levels from asynchronous comparators
// Notes:   First stage feeds only the second stage
`timescale 1ns/10ps
module fpc_sync #(
    parameter int W = 9
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Levels
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } fpc_sync_st_t;

    fpc_sync_st_t q_reg;
    fpc_sync_st_t q_next;

    always_comb begin
        q_next = q_reg;
        q_next.s1 = async_i;
        q_next.s2 = q_reg.s1;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_reg <= '0;
        end else begin
            q_reg <= q_next;
        end
    end

    assign sync_o = q_reg.s2;

endmodule : fpc_sync

// *** logic/fpc_cyc_count.sv ***
// Purpose: Counts consecutive hits, one per step, and trips at N
// Assumes: step_i is a one-cycle pulse, at most one per switching cycle
// Notes:   Trip holds until clear_i; a miss before the trip restarts at 0
`timescale 1ns/10ps
module fpc_cyc_count #(
    parameter int N = 4
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Events
    input wire logic step_i,
    input wire logic hit_i,
    input wire logic clear_i,
    // Result
    output logic trip_o
);
    localparam logic [3:0] LAST = 4'(N - 1);

    typedef struct packed {
        logic [3:0] cnt;
        logic trip;
    } fpc_cnt_st_t;

    fpc_cnt_st_t q_reg;
    fpc_cnt_st_t q_next;

    always_comb begin
        q_next = q_reg;
        if (clear_i) begin
            q_next = '0;
        end else if (step_i && !q_reg.trip) begin
            if (hit_i) begin
                if (q_reg.cnt == LAST) begin
                    q_next.trip = 1'b1;
                end else begin
                    q_next.cnt = q_reg.cnt + 4'h1;
                end
            end else begin
                q_next.cnt = 4'h0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_reg <= '0;
        end else begin
            q_reg <= q_next;
        end
    end

    assign trip_o = q_reg.trip;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_miss_clears_count: assert property (
        (step_i && !hit_i && !clear_i && !trip_o) |=> (q_reg.cnt == 4'h0))
        else $error("count not cleared by a miss");
    a_trip_needs_run: assert property (
        $rose(trip_o) |-> ($past(q_reg.cnt) == LAST && $past(hit_i)))
        else $error("trip without full run of hits");
    a_trip_stays_set: assert property (
        (trip_o && !clear_i) |=> trip_o)
        else $error("trip dropped without clear");

endmodule : fpc_cyc_count

// *** logic/fpc_top.sv ***
// Purpose: Mode, timing and protection sequencing of a flyback controller
// Assumes: Analog comparators give levels; reset only at supply power-up
// Notes:   Gate, sample strobe and supply controls all come from flops
`timescale 1ns/10ps
// Operation
// - Overload timer runs while control level exceeds the overload level.
// - Overpower protection fires after 60 ms of unbroken overload.
// - Overpower restart discharges and recharges the supply three times.
// - Current comparator ends the gate on-time when current hits level.
// - Current comparator ignored during blanking after each turn-on.
// - Sense input sampled once per cycle, 2 us after gate falls.
// - Four consecutive sense overvoltage samples latch the converter off.
// - Four consecutive supply overvoltage cycles latch the converter off.
// - Supply overvoltage count clears when supply drops before four.
// - High power runs a fixed 65 kHz period, peak current varies.
// - Peak power mode raises both frequency and peak current.
// - Low power clamps peak at 25 percent and lowers frequency.
// - Line compensation output off while in low power.
// - Over-temperature stops switching.
// - Over-temperature is latched until supply power is removed.
// - Latched protection enters power-down at once with supply clamp.
// - Eight maximum-duty strokes trigger one discharge and recharge restart.
// - Supply below lockout stops switching, waits for start level.
module fpc_top
    import fpc_pkg::*;
#(
    parameter int OVL_LIMIT = fpc_pkg::OVL_CYCLES
) (
    // Clock and reset
    input wire logic SYS_CLK_I,
    input wire logic RST_I,
    // Comparator levels from the analog front end
    input wire logic OVERLOAD_I,
    input wire logic CUR_TRIP_I,
    input wire logic SENSE_OVP_I,
    input wire logic VCC_OVP_I,
    input wire logic VCC_UNDERVOLTAGE_LOCKOUT_I,
    input wire logic VCC_START_I,
    input wire logic OTP_I,
    input wire logic LOW_POWER_I,
    input wire logic PEAK_POWER_I,
    // Power stage and supply controls
    output logic GATE_O,
    output logic SAMPLE_O,
    output logic [1:0] PEAK_SEL_O,
    output logic LINE_COMP_EN_O,
    output logic RESTART_LOAD_O,
    output logic POWER_DOWN_O,
    output logic VCC_CLAMP_O,
    // Register port
    input wire logic [3:0] ADDR_I,
    input wire logic [31:0] WR_DATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [31:0] RD_DATA_O
);
    import fpc_pkg::*;

    localparam logic [22:0] OVL_LAST = 23'(OVL_LIMIT - 1);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        fpc_state_t st;
        fpc_mode_t mode;
        logic [12:0] per_cnt;
        logic [12:0] per_len;
        logic [12:0] on_max;
        logic [12:0] on_cnt;
        logic drv;
        logic [7:0] smp_cnt;
        logic smp;
        logic [22:0] ovl_cnt;
        logic [1:0] rst_left;
        logic en;
        logic [2:0] cause;
        logic pd;
        logic clamp;
        logic dis;
        logic lcomp;
        logic [31:0] rdata;
    } fpc_top_st_t;

    fpc_top_st_t q_reg;
    fpc_top_st_t q_next;

    logic [IN_W-1:0] in_s;
    logic sense_trip;
    logic vcc_trip;
    logic duty_trip;
    logic sense_step;
    logic vcc_step;
    logic duty_step;
    logic duty_hit;
    logic cnt_clear;
    logic opp_fire;
    fpc_mode_t mode_now;

    // ------------------------------------------------------------
    // Input synchroniser and cycle counters
    // ------------------------------------------------------------
    fpc_sync #(.W(IN_W)) u_sync (
        .clk_i(SYS_CLK_I),
        .rst_i(RST_I),
        .async_i({PEAK_POWER_I, LOW_POWER_I, OTP_I, VCC_START_I,
                  VCC_UNDERVOLTAGE_LOCKOUT_I, VCC_OVP_I, SENSE_OVP_I, CUR_TRIP_I,
                  OVERLOAD_I}),
        .sync_o(in_s)
    );

    assign cnt_clear = (q_reg.st != ST_RUN);

    fpc_cyc_count #(.N(OVP_COUNT)) u_sense_cnt (
        .clk_i(SYS_CLK_I),
        .rst_i(RST_I),
        .step_i(sense_step),
        .hit_i(in_s[IN_SOVP]),
        .clear_i(cnt_clear),
        .trip_o(sense_trip)
    );

    fpc_cyc_count #(.N(OVP_COUNT)) u_vcc_cnt (
        .clk_i(SYS_CLK_I),
        .rst_i(RST_I),
        .step_i(vcc_step),
        .hit_i(in_s[IN_VOVP]),
        .clear_i(cnt_clear),
        .trip_o(vcc_trip)
    );

    fpc_cyc_count #(.N(DUTY_COUNT)) u_duty_cnt (
        .clk_i(SYS_CLK_I),
        .rst_i(RST_I),
        .step_i(duty_step),
        .hit_i(duty_hit),
        .clear_i(cnt_clear),
        .trip_o(duty_trip)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        q_next = q_reg;
        q_next.smp = 1'b0;
        sense_step = 1'b0;
        vcc_step = 1'b0;
        duty_step = 1'b0;
        duty_hit = 1'b0;
        opp_fire = 1'b0;
        if (in_s[IN_LOW]) begin
            mode_now = MD_LOW;
        end else if (in_s[IN_PEAK]) begin
            mode_now = MD_PEAK;
        end else begin
            mode_now = MD_HIGH;
        end

        // Software writes and registered reads
        if (WR_I && ADDR_I == REG_CONFIG) begin
            q_next.en = WR_DATA_I[CFG_EN_BIT];
        end
        q_next.rdata = 32'h0000_0000;
        if (RD_I) begin
            case (ADDR_I)
                REG_STATUS: begin
                    q_next.rdata[ST_STATE_LSB +: 3] = q_reg.st;
                    q_next.rdata[ST_MODE_LSB +: 2] = q_reg.mode;
                    q_next.rdata[ST_EN_BIT] = q_reg.en;
                    q_next.rdata[ST_CAUSE_LSB +: 3] = q_reg.cause;
                end
                REG_CONFIG: begin
                    q_next.rdata[CFG_EN_BIT] = q_reg.en;
                end
                default: begin
                    q_next.rdata = 32'h0000_0000;
                end
            endcase
        end

        case (q_reg.st)
            ST_WAIT: begin
                q_next.drv = 1'b0;
                q_next.pd = 1'b0;
                q_next.dis = 1'b0;
                if (q_reg.en && in_s[IN_START] && !in_s[IN_UNDERVOLTAGE_LOCKOUT]) begin
                    q_next.st = ST_RUN;
                    q_next.per_cnt = 13'h0000;
                end
            end
            ST_RUN: begin
                if (in_s[IN_OVL]) begin
                    if (q_reg.ovl_cnt == OVL_LAST) begin
                        opp_fire = 1'b1;
                    end else begin
                        q_next.ovl_cnt = q_reg.ovl_cnt + 23'h00_0001;
                    end
                end else begin
                    q_next.ovl_cnt = 23'h00_0000;
                end

                if (q_reg.per_cnt == q_reg.per_len - 13'h0001 ||
                    q_reg.per_len == 13'h0000) begin
                    q_next.per_cnt = 13'h0000;
                end else begin
                    q_next.per_cnt = q_reg.per_cnt + 13'h0001;
                end

                if (q_reg.drv) begin
                    q_next.on_cnt = q_reg.on_cnt + 13'h0001;
                    if ((in_s[IN_TRIP] && q_reg.on_cnt >= BLANK_CYCLES) ||
                        q_reg.on_cnt == q_reg.on_max - 13'h0001) begin
                        q_next.drv = 1'b0;
                        q_next.smp_cnt = SAMPLE_CYCLES;
                        duty_step = 1'b1;
                        duty_hit = (q_reg.on_cnt == q_reg.on_max - 13'h0001);
                    end
                end else if (q_reg.per_cnt == 13'h0000) begin
                    // mode fixes period and peak level
                    q_next.mode = mode_now;
                    case (mode_now)
                        MD_LOW: begin
                            q_next.per_len = LP_PERIOD;
                            q_next.on_max = LP_MAXON;
                        end
                        MD_PEAK: begin
                            q_next.per_len = PP_PERIOD;
                            q_next.on_max = PP_MAXON;
                        end
                        default: begin
                            q_next.per_len = HP_PERIOD;
                            q_next.on_max = HP_MAXON;
                        end
                    endcase
                    q_next.drv = 1'b1;
                    q_next.on_cnt = 13'h0000;
                    vcc_step = 1'b1;
                end

                if (q_reg.smp_cnt != 8'h00) begin
                    q_next.smp_cnt = q_reg.smp_cnt - 8'h01;
                    if (q_reg.smp_cnt == 8'h01) begin
                        q_next.smp = 1'b1;
                        sense_step = 1'b1;
                    end
                end

                q_next.lcomp = (q_next.mode != MD_LOW);

                if (sense_trip || vcc_trip) begin
                    q_next.st = ST_LATCH;
                    q_next.cause[CAUSE_SENSE] = sense_trip;
                    q_next.cause[CAUSE_VCC] = vcc_trip;
                end else if (in_s[IN_UNDERVOLTAGE_LOCKOUT]) begin
                    q_next.st = ST_WAIT;
                end else if (opp_fire) begin
                    q_next.st = ST_DISCH;
                    q_next.rst_left = 2'(OPP_RESTARTS);
                end else if (duty_trip) begin
                    q_next.st = ST_DISCH;
                    q_next.rst_left = 2'(ONE_RESTART);
                end else if (!q_reg.en) begin
                    q_next.st = ST_WAIT;
                end
                if (q_next.st != ST_RUN) begin
                    q_next.drv = 1'b0;
                    q_next.smp_cnt = 8'h00;
                    q_next.smp = 1'b0;
                    q_next.ovl_cnt = 23'h00_0000;
                    q_next.lcomp = 1'b0;
                    q_next.dis = (q_next.st == ST_DISCH);
                end
            end
            ST_DISCH: begin
                q_next.dis = 1'b1;
                if (in_s[IN_UNDERVOLTAGE_LOCKOUT]) begin
                    q_next.st = ST_CHARGE;
                    q_next.dis = 1'b0;
                    q_next.pd = 1'b1;
                end
            end
            ST_CHARGE: begin
                q_next.pd = 1'b1;
                if (in_s[IN_START]) begin
                    q_next.pd = 1'b0;
                    if (q_reg.rst_left > 2'h1) begin
                        q_next.rst_left = q_reg.rst_left - 2'h1;
                        q_next.st = ST_DISCH;
                        q_next.dis = 1'b1;
                    end else begin
                        q_next.rst_left = 2'h0;
                        q_next.st = ST_WAIT;
                    end
                end
            end
            ST_LATCH: begin
                q_next.drv = 1'b0;
            end
            default: begin
                q_next.st = ST_WAIT;
            end
        endcase

        if (in_s[IN_OTP] && q_reg.st != ST_LATCH) begin
            q_next.st = ST_LATCH;
            q_next.cause[CAUSE_OTP] = 1'b1;
        end
        if (q_next.st == ST_LATCH) begin
            q_next.drv = 1'b0;
            q_next.smp = 1'b0;
            q_next.smp_cnt = 8'h00;
            q_next.lcomp = 1'b0;
            q_next.dis = 1'b0;
            q_next.pd = 1'b1;
            q_next.clamp = 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            q_reg <= '0;
            q_reg.st <= ST_WAIT;
            q_reg.mode <= MD_HIGH;
            q_reg.per_len <= HP_PERIOD;
            q_reg.on_max <= HP_MAXON;
            q_reg.en <= CFG_EN_RESET;
        end else begin
            q_reg <= q_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign GATE_O = q_reg.drv;
    assign SAMPLE_O = q_reg.smp;
    assign PEAK_SEL_O = q_reg.mode;
    assign LINE_COMP_EN_O = q_reg.lcomp;
    assign RESTART_LOAD_O = q_reg.dis;
    assign POWER_DOWN_O = q_reg.pd;
    assign VCC_CLAMP_O = q_reg.clamp;
    assign RD_DATA_O = q_reg.rdata;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (RST_I);

    sequence s_opp_timeout;
        q_reg.st == ST_RUN && opp_fire && !sense_trip && !vcc_trip &&
            !in_s[IN_UNDERVOLTAGE_LOCKOUT] && !in_s[IN_OTP];
    endsequence

    sequence s_three_rounds;
        q_reg.st == ST_DISCH && q_reg.rst_left == 2'h3 && RESTART_LOAD_O;
    endsequence

    a_opp_enters_restart: assert property (
        s_opp_timeout |=> s_three_rounds)
        else $error("overpower did not start three restart rounds");
    a_otp_latches_off: assert property (
        (in_s[IN_OTP] && q_reg.st != ST_LATCH) |=>
            (q_reg.st == ST_LATCH && !GATE_O && q_reg.cause[CAUSE_OTP]))
        else $error("over-temperature did not latch off");
    a_latch_never_exits: assert property (
        (q_reg.st == ST_LATCH) |=> (q_reg.st == ST_LATCH))
        else $error("latched state left");
    a_latch_clamps_supply: assert property (
        (q_reg.st == ST_LATCH) |-> (VCC_CLAMP_O && POWER_DOWN_O && !GATE_O))
        else $error("latched state without clamp or with gate");
    a_blank_holds_gate: assert property (
        $rose(GATE_O) |-> (GATE_O || q_reg.st != ST_RUN) [*8])
        else $error("pulse ended inside blanking");
    a_sample_after_fall: assert property (
        ($fell(GATE_O) && q_reg.st == ST_RUN) |->
            ##200 (SAMPLE_O || q_reg.st != ST_RUN))
        else $error("sense sample not 2 us after gate fall");
    a_overload_clears: assert property (
        (q_reg.st == ST_RUN && !in_s[IN_OVL]) |=> (q_reg.ovl_cnt == 23'h0))
        else $error("overload timer kept after overload ended");
    a_low_power_peak: assert property (
        (q_reg.st == ST_RUN && q_reg.mode == MD_LOW) |->
            (!LINE_COMP_EN_O && PEAK_SEL_O == MD_LOW))
        else $error("low power with compensation or wrong peak level");
    a_undervoltage_lockout_stops_gate: assert property (
        (q_reg.st == ST_RUN && in_s[IN_UNDERVOLTAGE_LOCKOUT] && !in_s[IN_OTP] &&
            !sense_trip && !vcc_trip) |=> (q_reg.st == ST_WAIT && !GATE_O))
        else $error("lockout did not stop switching");
    a_high_period_fixed: assert property (
        ($rose(GATE_O) && q_reg.mode == MD_HIGH && q_reg.st == ST_RUN) |->
            (q_reg.per_len == HP_PERIOD))
        else $error("high power period not fixed");

endmodule : fpc_top

// *** tb/fpc_plant.sv ***
// Purpose: Power switch, sense and supply model
// Assumes: Supply moves one step a cycle
// Notes: Aux winding holds supply up while running
`timescale 1ns/10ps
module fpc_plant (
    // Clock and controls
    input wire logic clk_i,
    input wire logic gate_i,
    input wire logic load_i,
    input wire logic [31:0] trip_len_i,
    // Comparator levels
    output logic trip_o,
    output logic undervoltage_lockout_o,
    output logic start_o
);
    int vcc = 0;
    int on_cnt = 0;
    always @(posedge clk_i) begin
        vcc <= load_i ? vcc - 1 : (vcc < 90 ? vcc + 1 : vcc);
        on_cnt <= gate_i ? on_cnt + 1 : 0;
    end
    // Current ramps only while the switch conducts
    assign trip_o = gate_i && on_cnt >= trip_len_i;
    assign undervoltage_lockout_o = vcc < 20;
    assign start_o = vcc >= 80;
endmodule : fpc_plant

// *** tb/tb_fpc_top.sv ***
// Purpose: Self-checking bench of the protection control
// Assumes: Overload limit shortened to 50 cycles
// Notes: Expected periods come from the package constants
`timescale 1ns/10ps
module tb_fpc_top;
    import fpc_pkg::*;
    logic clk = 0, rst = 1, ovl = 0, sovp = 0, vovp = 0, otp = 0;
    logic low = 0, peak = 0, wr = 0, rd = 0, gate, smp, lc, ld, pd, clamp;
    logic trip, uv, st;
    logic [1:0] sel;
    logic [3:0] addr = 4'h0;
    logic [31:0] wd = 32'h0, d, rdd, seed = 32'h0DC23727;
    int trip_len = 100, mismatches = 0, n_checks = 0, cyc = 0, n, a;
    always #5 clk = ~clk;
    fpc_plant plant (.clk_i(clk), .gate_i(gate), .load_i(ld),
        .trip_len_i(trip_len), .trip_o(trip), .undervoltage_lockout_o(uv), .start_o(st));
    fpc_top #(.OVL_LIMIT(50)) dut (.SYS_CLK_I(clk), .RST_I(rst),
        .OVERLOAD_I(ovl), .CUR_TRIP_I(trip), .SENSE_OVP_I(sovp),
        .VCC_OVP_I(vovp), .VCC_UNDERVOLTAGE_LOCKOUT_I(uv), .VCC_START_I(st), .OTP_I(otp),
        .LOW_POWER_I(low), .PEAK_POWER_I(peak), .GATE_O(gate),
        .SAMPLE_O(smp), .PEAK_SEL_O(sel), .LINE_COMP_EN_O(lc),
        .RESTART_LOAD_O(ld), .POWER_DOWN_O(pd), .VCC_CLAMP_O(clamp),
        .ADDR_I(addr), .WR_DATA_I(wd), .WR_I(wr), .RD_I(rd),
        .RD_DATA_O(rdd));
    // Ceiling well above the expected run length
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 99000) begin
            mismatches++;
            tally_and_finish();
        end
    end
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction : xs
    function automatic int exp_per(input int m);
        return m == 1 ? LP_PERIOD : (m == 2 ? PP_PERIOD : HP_PERIOD);
    endfunction : exp_per
    task automatic tk(input int k = 1);
        repeat (k) @(posedge clk);
        #1;
    endtask : tk
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task automatic rdr(input logic [3:0] ad);
        addr <= ad;
        rd <= 1;
        tk();
        rd <= 0;
        d = rdd;
    endtask : rdr
    task automatic wrr(input logic [3:0] ad, input logic [31:0] v);
        addr <= ad;
        wd <= v;
        wr <= 1;
        tk();
        wr <= 0;
    endtask : wrr
    // Cycles until gate (s=0), sample (1) or clamp (2) reaches v
    task automatic wt(input int s, input logic v);
        n = 0;
        while ((s == 0 ? gate : s == 1 ? smp : clamp) !== v && n < 9000) begin
            tk();
            n++;
        end
    endtask : wt
    // Discharge rounds until switching resumes
    task automatic rounds(output int r);
        logic p;
        p = 0;
        r = 0;
        for (int i = 0; i < 40000 && !(gate === 1'b1 && r > 0); i++) begin
            tk();
            if (i == 70) ovl <= 0;
            r += (ld === 1'b1 && p === 1'b0);
            p = ld;
        end
    endtask : rounds
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : tally_and_finish
    initial begin
        tk(8);
        rst <= 0;
        rdr(REG_STATUS);
        chk(d, 32'h20);
        addr <= REG_STATUS;
        wd <= 32'hFF;
        wr <= 1;
        tk();
        wr <= 0;
        rdr(4'h8);
        chk(d, 32'h0);
        for (int m = 0; m < 3; m++) begin
            seed = xs(seed);
            trip_len <= m == 0 ? 0 : 40 + seed % 400;
            low <= m == 1;
            peak <= m == 2;
            wt(0, 0); wt(0, 1); wt(0, 0); wt(0, 1); wt(0, 0);
            a = n;
            // Zero trip length exposes the blanking floor
            if (m == 0) chk(a >= 31 && a < 40, 1);
            else chk(a > trip_len && a < trip_len + 8, 1);
            wt(1, 1);
            chk(n, SAMPLE_CYCLES);
            a += n;
            wt(0, 1);
            chk(a + n, exp_per(m));
            chk(sel, m);
            chk(lc, m != 1);
        end
        $display("mode test done");
        // Disabled long enough that no sample is still pending
        wrr(REG_CONFIG, 32'h0);
        tk(300);
        rdr(REG_CONFIG);
        chk(d, 32'h0);
        tk();
        rdr(REG_STATUS);
        chk(d & 32'h27, 32'h0);
        chk(gate, 0);
        wrr(REG_CONFIG, 32'h1);
        trip_len <= 9000;
        rounds(n);
        chk(n, 1);
        trip_len <= 100;
        ovl <= 1;
        rounds(n);
        chk(n, 3);
        // Two short overloads with a gap must not add up to a timeout
        ovl <= 1;
        tk(40);
        ovl <= 0;
        tk(2);
        ovl <= 1;
        tk(40);
        ovl <= 0;
        tk(3);
        chk(ld, 0);
        // Runs of two or three hits broken by a miss never latch
        for (int k = 0; k < 2; k++) begin
            {sovp, vovp} <= 2'b11;
            tk(PP_PERIOD * 5 / 2);
            {sovp, vovp} <= 2'b00;
            tk(PP_PERIOD * 3 / 2);
        end
        chk(clamp, 0);
        $display("restart test done");
        for (int i = 0; i < 3; i++) begin
            otp <= i == 0;
            sovp <= i == 1;
            vovp <= i == 2;
            wt(2, 1);
            chk({pd, gate}, 2'b10);
            {otp, sovp, vovp} <= 3'b000;
            tk(500);
            rdr(REG_STATUS);
            chk(d & 32'h1C7, 32'h4 | (32'h40 << i));
            rst <= 1;
            tk(8);
            rst <= 0;
        end
        $display("latch test done");
        tally_and_finish();
    end
endmodule : tb_fpc_top
